// File: src/ffs_pkg.sv
// Shared types and constants for the fixed frequency sequencer
package ffs_pkg;

  localparam int STEP_N  = 8;
  localparam int DI_N    = 6;
  localparam int TIME_W  = 10;
  localparam int FREQ_W  = 16;
  localparam int SEL_W   = 3;
  localparam int FN_W    = 5;
  localparam int TICK_W  = 26;
  localparam int HOLD_W  = 23;

  // Clock and derived timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEC_NS        = 1000000000;
  localparam int SEC_CYC       = SEC_NS / CLK_PERIOD_NS;
  localparam int EVT_HOLD_MS   = 100;
  localparam int EVT_HOLD_CYC  = (EVT_HOLD_MS * 1000000) / CLK_PERIOD_NS;

  // Sequence mode codes
  localparam logic [2:0] MODE_ONCE      = 3'h1;
  localparam logic [2:0] MODE_CONT      = 3'h2;
  localparam logic [2:0] MODE_STEP_ONCE = 3'h3;
  localparam logic [2:0] MODE_STEP_CONT = 3'h4;

  // Output function codes
  localparam logic [FN_W-1:0] FN_RUNNING  = 5'h10;
  localparam logic [FN_W-1:0] FN_STEP_END = 5'h11;
  localparam logic [FN_W-1:0] FN_CYC_END  = 5'h12;
  localparam logic [FN_W-1:0] FN_PAUSED   = 5'h13;

  typedef enum logic [1:0] {
    FFS_IDLE = 2'h0,
    FFS_RUN  = 2'h1,
    FFS_GAP  = 2'h3,
    FFS_DONE = 2'h2
  } ffs_state_t;

  typedef struct packed {
    logic [SEL_W-1:0]                   sequence_start_input_select;
    logic [SEL_W-1:0]                   sequence_pause_input_select;
    logic                               stop_method_select;
    logic [2:0]                         sequence_mode_select;
    logic [STEP_N-1:0]                  direction_program_number;
    logic [STEP_N-1:0][TIME_W-1:0]      step_run_times;
    logic [STEP_N-1:0][FREQ_W-1:0]      fixed_frequency_setpoints;
    logic [FN_W-1:0]                    relay1_function_select;
    logic [FN_W-1:0]                    relay2_function_select;
    logic [FN_W-1:0]                    transistor_output_function_select;
  } ffs_cfg_t;

  typedef struct packed {
    logic              override;
    logic              run;
    logic              coast;
    logic              reverse_direction;
    logic [2:0]        step;
    logic [FREQ_W-1:0] freq;
  } ffs_drive_t;

endpackage

// File: src/ffs_sequencer.sv
// Fixed frequency sequencer: eight timed steps with direction, pause and status outputs
//
// Overview of operation
// - Sequencer starts at power-up if the start input is already high.
// - Start removed mid-cycle stops the drive by stop method and ends the program.
// - A new start after removal restarts from the first active step.
// - Pause input freezes the sequence; release resumes the same step.
// - Function 16 shows running; in modes 1 and 3 it drops at cycle end.
// - In modes 2 and 4 running stays on until start is removed.
// - Function 17 signals each step run-time expiry.
// - Function 18 signals completion of a full cycle.
// - Function 19 shows that pause is in effect.
// - Mode 1 runs active steps once in ascending order for their run times.
// - Program 192 reverses the two highest steps, others forward.
// - Stepped modes bring frequency to zero by stop method between steps.
// - Stepped modes still apply per-step direction.
// - Mode codes: 1 once, 2 continuous, 3 stepped once, 4 stepped continuous.
// - Bit n of the direction program: 0 forward, 1 reverse for step n.
// - Steps with zero run time are inactive and skipped.
// - Sequencer start and setpoints override all other commands and sources.
`timescale 1ns/1ps

module ffs_sequencer
  import ffs_pkg::*;
#(
  parameter int unsigned TICK_CYC = SEC_CYC,
  parameter int unsigned HOLD_CYC = EVT_HOLD_CYC
) (
  input  wire logic            ref_clk,
  input  wire logic            srst,
  input  wire logic [DI_N-1:0] digital_inputs,
  input  wire ffs_cfg_t        cfg,
  input  wire logic            zero_speed,
  output ffs_drive_t           drive_cmd,
  output logic                 relay_output_one,
  output logic                 relay_output_two,
  output logic                 transistor_output
);

  typedef struct packed {
    ffs_state_t        st;
    logic [DI_N-1:0]   di_s1;
    logic [DI_N-1:0]   di_s2;
    logic [DI_N-1:0]   di_s3;
    logic [DI_N-1:0]   di_f;
    logic [TIME_W-1:0] sec_cnt;
    logic [TICK_W-1:0] tick_cnt;
    logic [HOLD_W-1:0] step_hold;
    logic [HOLD_W-1:0] cyc_hold;
    logic              running;
    logic              paused;
    ffs_drive_t        drv;
    logic              ro1;
    logic              ro2;
    logic              dout;
  } ffs_regs_t;

  ffs_regs_t q_r;
  ffs_regs_t q_nxt;

  // Input select 1..6 picks a filtered pin, 0 or above 6 means unassigned
  function automatic logic pick_input(input logic [DI_N-1:0] di, input logic [SEL_W-1:0] sel);
    logic v;
    v = 1'b0;
    for (int i = 0; i < DI_N; i++) begin
      if (sel == SEL_W'(i + 1)) begin
        v = di[i];
      end
    end
    return v;
  endfunction

  // First active step at or above from; bit 3 set when one was found
  function automatic logic [3:0] find_active(input logic [STEP_N-1:0][TIME_W-1:0] t, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = STEP_N - 1; i >= 0; i--) begin
      if (4'(i) >= from && t[i] != '0) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic fn_level(input logic [FN_W-1:0] code, input logic run, input logic se,
                                    input logic ce, input logic pz);
    logic v;
    v = 1'b0;
    unique case (code)
      FN_RUNNING:  v = run;
      FN_STEP_END: v = se;
      FN_CYC_END:  v = ce;
      FN_PAUSED:   v = pz;
      default:     v = 1'b0;
    endcase
    return v;
  endfunction

  logic       start_lvl;
  logic       pause_lvl;
  logic       mode_ok;
  logic       stepped;
  logic       continuous;
  logic [3:0] first_act;
  logic [3:0] next_act;
  logic       sec_tick;
  logic       expire;

  always_comb begin
    start_lvl  = pick_input(q_r.di_f, cfg.sequence_start_input_select);
    pause_lvl  = pick_input(q_r.di_f, cfg.sequence_pause_input_select);
    mode_ok    = cfg.sequence_mode_select >= MODE_ONCE && cfg.sequence_mode_select <= MODE_STEP_CONT;
    stepped    = cfg.sequence_mode_select == MODE_STEP_ONCE || cfg.sequence_mode_select == MODE_STEP_CONT;
    continuous = cfg.sequence_mode_select == MODE_CONT || cfg.sequence_mode_select == MODE_STEP_CONT;
    first_act  = find_active(cfg.step_run_times, 4'h0);
    next_act   = find_active(cfg.step_run_times, 4'({1'b0, q_r.drv.step}) + 4'h1);
    sec_tick   = q_r.tick_cnt == TICK_W'(TICK_CYC - 1);
    expire     = sec_tick && (q_r.sec_cnt + 10'h001) >= cfg.step_run_times[q_r.drv.step];
  end

  always_comb begin
    q_nxt       = q_r;
    q_nxt.di_s1 = digital_inputs;
    q_nxt.di_s2 = q_r.di_s1;
    q_nxt.di_s3 = q_r.di_s2;
    for (int i = 0; i < DI_N; i++) begin
      if (q_r.di_s2[i] == q_r.di_s3[i]) begin
        q_nxt.di_f[i] = q_r.di_s3[i];
      end
    end
    if (q_r.step_hold != '0) begin
      q_nxt.step_hold = q_r.step_hold - HOLD_W'(1);
    end
    if (q_r.cyc_hold != '0) begin
      q_nxt.cyc_hold = q_r.cyc_hold - HOLD_W'(1);
    end
    q_nxt.drv.coast = cfg.stop_method_select;
    q_nxt.paused    = 1'b0;

    unique case (q_r.st)
      FFS_IDLE: begin
        q_nxt.running      = 1'b0;
        q_nxt.drv.run      = 1'b0;
        q_nxt.drv.override = 1'b0;
        q_nxt.drv.freq     = '0;
        if (start_lvl && mode_ok) begin
          q_nxt.running      = 1'b1;
          q_nxt.drv.override = 1'b1;
          q_nxt.sec_cnt      = '0;
          q_nxt.tick_cnt     = '0;
          if (first_act[3]) begin
            q_nxt.st                    = FFS_RUN;
            q_nxt.drv.run               = 1'b1;
            q_nxt.drv.step              = first_act[2:0];
            q_nxt.drv.freq              = cfg.fixed_frequency_setpoints[first_act[2:0]];
            q_nxt.drv.reverse_direction = cfg.direction_program_number[first_act[2:0]];
          end else begin
            q_nxt.st = FFS_DONE;
          end
        end
      end
      FFS_RUN, FFS_GAP: begin
        if (!start_lvl) begin
          q_nxt.st           = FFS_IDLE;
          q_nxt.drv.run      = 1'b0;
          q_nxt.drv.freq     = '0;
          q_nxt.running      = 1'b0;
          q_nxt.drv.override = 1'b0;
        end else if (pause_lvl) begin
          q_nxt.paused  = 1'b1;
          q_nxt.drv.run = 1'b0;
        end else if (q_r.st == FFS_GAP) begin
          q_nxt.drv.run  = 1'b0;
          q_nxt.drv.freq = '0;
          if (zero_speed) begin
            q_nxt.st                    = FFS_RUN;
            q_nxt.drv.run               = 1'b1;
            q_nxt.drv.freq              = cfg.fixed_frequency_setpoints[q_r.drv.step];
            q_nxt.drv.reverse_direction = cfg.direction_program_number[q_r.drv.step];
            q_nxt.sec_cnt               = '0;
            q_nxt.tick_cnt              = '0;
          end
        end else begin
          q_nxt.drv.run  = 1'b1;
          q_nxt.tick_cnt = sec_tick ? '0 : q_r.tick_cnt + TICK_W'(1);
          if (sec_tick) begin
            q_nxt.sec_cnt = q_r.sec_cnt + 10'h001;
          end
          if (expire) begin
            q_nxt.step_hold = HOLD_W'(HOLD_CYC);
            q_nxt.sec_cnt   = '0;
            if (next_act[3]) begin
              q_nxt.drv.step = next_act[2:0];
            end else begin
              q_nxt.cyc_hold = HOLD_W'(HOLD_CYC);
              q_nxt.drv.step = first_act[2:0];
            end
            if (!next_act[3] && !continuous) begin
              q_nxt.st       = FFS_DONE;
              q_nxt.drv.run  = 1'b0;
              q_nxt.drv.freq = '0;
              q_nxt.running  = 1'b0;
            end else if (stepped) begin
              q_nxt.st       = FFS_GAP;
              q_nxt.drv.run  = 1'b0;
              q_nxt.drv.freq = '0;
            end else begin
              q_nxt.drv.freq              = cfg.fixed_frequency_setpoints[q_nxt.drv.step];
              q_nxt.drv.reverse_direction = cfg.direction_program_number[q_nxt.drv.step];
            end
          end else begin
            q_nxt.drv.freq = cfg.fixed_frequency_setpoints[q_r.drv.step];
          end
        end
      end
      FFS_DONE: begin
        q_nxt.drv.run  = 1'b0;
        q_nxt.drv.freq = '0;
        q_nxt.running  = continuous;
        if (!start_lvl) begin
          q_nxt.st           = FFS_IDLE;
          q_nxt.running      = 1'b0;
          q_nxt.drv.override = 1'b0;
        end
      end
    endcase

    q_nxt.ro1  = fn_level(cfg.relay1_function_select, q_nxt.running, q_nxt.step_hold != '0,
                          q_nxt.cyc_hold != '0, q_nxt.paused);
    q_nxt.ro2  = fn_level(cfg.relay2_function_select, q_nxt.running, q_nxt.step_hold != '0,
                          q_nxt.cyc_hold != '0, q_nxt.paused);
    q_nxt.dout = fn_level(cfg.transistor_output_function_select, q_nxt.running, q_nxt.step_hold != '0,
                          q_nxt.cyc_hold != '0, q_nxt.paused);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q_r    <= '0;
      q_r.st <= FFS_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign drive_cmd         = q_r.drv;
  assign relay_output_one  = q_r.ro1;
  assign relay_output_two  = q_r.ro2;
  assign transistor_output = q_r.dout;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence step_expires_s;
    q_r.st == FFS_RUN && !pause_lvl && start_lvl && expire;
  endsequence

  sequence gap_then_zero_s;
    q_r.st == FFS_GAP ##0 (!q_r.drv.run && q_r.drv.freq == '0);
  endsequence

  auto_start_a : assert property (
    q_r.st == FFS_IDLE && start_lvl && mode_ok && first_act[3] |=> q_r.st == FFS_RUN && q_r.drv.run && q_r.running)
    else $error("sequence did not start on a held start level");

  start_abort_a : assert property (
    (q_r.st == FFS_RUN || q_r.st == FFS_GAP) && !start_lvl |=> q_r.st == FFS_IDLE && !q_r.drv.run && !q_r.running)
    else $error("start removal did not end the program");

  restart_first_a : assert property (
    q_r.st == FFS_IDLE && start_lvl && mode_ok && first_act[3] |=> q_r.drv.step == $past(first_act[2:0]))
    else $error("restart did not begin at first active step");

  pause_freeze_a : assert property (
    q_r.st == FFS_RUN && start_lvl && pause_lvl |=> $stable(q_r.drv.step) && $stable(q_r.sec_cnt) && !q_r.drv.run)
    else $error("pause did not freeze the sequence");

  single_end_a : assert property (
    step_expires_s ##0 (!next_act[3] && !continuous) |=> !q_r.running && q_r.st == FFS_DONE)
    else $error("running stayed on after single cycle");

  cont_running_a : assert property (
    continuous && start_lvl && q_r.st != FFS_IDLE && mode_ok |=> q_r.running)
    else $error("running dropped in continuous mode");

  step_event_a : assert property (
    step_expires_s |=> q_r.step_hold == HOLD_W'(HOLD_CYC))
    else $error("step end not signalled");

  cycle_event_a : assert property (
    step_expires_s ##0 !next_act[3] |=> q_r.cyc_hold == HOLD_W'(HOLD_CYC))
    else $error("cycle end not signalled");

  pause_flag_a : assert property (
    q_r.st == FFS_RUN && start_lvl && pause_lvl |=> q_r.paused)
    else $error("pause not indicated");

  ascend_order_a : assert property (
    step_expires_s ##0 next_act[3] |=> q_r.drv.step > $past(q_r.drv.step))
    else $error("steps not taken in ascending order");

  step_dir_a : assert property (
    q_r.st == FFS_RUN && $changed(q_r.drv.step) |-> q_r.drv.reverse_direction ==
      $past(cfg.direction_program_number[q_nxt.drv.step]))
    else $error("step direction does not match program bit");

  gap_zero_a : assert property (
    step_expires_s ##0 stepped ##0 (next_act[3] || continuous) |=> gap_then_zero_s)
    else $error("stepped mode did not stop between steps");

  skip_zero_a : assert property (
    q_r.st == FFS_RUN && $changed(q_r.drv.step) |-> $past(cfg.step_run_times[q_nxt.drv.step]) != '0)
    else $error("inactive step was entered");

endmodule

// File: verif/ffs_drive_model.sv
// Drive model: reports zero speed a while after the run command drops
`timescale 1ns/1ps

module ffs_drive_model
  import ffs_pkg::*;
#(
  parameter int RAMP = 6
) (
  input  wire logic       ref_clk,
  input  wire ffs_drive_t drive_cmd,
  output logic            zero_speed
);
  int ramp_r;

  // Stop ramp must run out before zero speed is reported
  always_ff @(posedge ref_clk) begin
    if (drive_cmd.run) begin
      ramp_r <= 0;
    end else if (ramp_r < RAMP) begin
      ramp_r <= ramp_r + 1;
    end
  end

  assign zero_speed = (ramp_r >= RAMP) && !drive_cmd.run;
endmodule

// File: verif/tb_fixed_frequency_sequencer.sv
// Self-checking testbench for the fixed frequency sequencer
`timescale 1ns/1ps

module tb_fixed_frequency_sequencer;
  import ffs_pkg::*;
  localparam int TICK = 20;
  localparam int HOLD = 4;

  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] dir;
    logic       run_after;
    logic       stepped;
  } ffs_row_t;

  logic             ref_clk;
  logic             srst;
  logic             zero_speed;
  logic             ro1;
  logic             ro2;
  logic             dout;
  logic [DI_N-1:0]  din;
  ffs_cfg_t         cfg;
  ffs_drive_t       drv;
  int               num_errors;
  int               checks;
  ffs_row_t         rows [4];
  logic [2:0]       seen_step [$];
  logic             seen_rev [$];
  logic [FREQ_W-1:0] seen_freq [$];
  logic             prev_run = 1'b0;
  logic [2:0]       prev_step = 3'h0;
  logic             ro2_prev = 1'b0;
  int               gaps, ends, cyc, t0;
  logic [2:0]       exp_steps [4] = '{3'h0, 3'h2, 3'h6, 3'h7};

  ffs_sequencer #(.TICK_CYC(TICK), .HOLD_CYC(HOLD)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .digital_inputs(din), .cfg(cfg), .zero_speed(zero_speed),
    .drive_cmd(drv), .relay_output_one(ro1), .relay_output_two(ro2), .transistor_output(dout));

  ffs_drive_model #(.RAMP(6)) u_drive (.ref_clk(ref_clk), .drive_cmd(drv), .zero_speed(zero_speed));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Records each step entered, gap cycles and step-end pulses
  always @(negedge ref_clk) begin
    if (drv.run === 1'b1 && (!prev_run || drv.step !== prev_step)) begin
      if (seen_step.size() == 0) t0 = cyc;
      seen_step.push_back(drv.step);
      seen_rev.push_back(drv.reverse_direction);
      seen_freq.push_back(drv.freq);
    end
    if (drv.override === 1'b1 && drv.run === 1'b0) gaps++;
    if (ro2 === 1'b1 && !ro2_prev) ends++;
    prev_run = (drv.run === 1'b1);
    prev_step = drv.step;
    ro2_prev = (ro2 === 1'b1);
    cyc++;
  end

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error: %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Start on the second input, pause on the fifth
  task automatic set_pins(logic st, logic pz);
    din = {1'b0, pz, 2'b00, st, 1'b0};
  endtask

  function automatic logic cond(int k);
    case (k)
      0: return dout;
      1: return drv.run;
      3: return drv.run && drv.step == 3'h2;
      default: return drv.run && drv.step == 3'h6;
    endcase
  endfunction

  task automatic wait_for(int k, int lim);
    int i;
    for (i = 0; i < lim && cond(k) !== 1'b1; i++) tick(1);
    if (i == lim) begin
      num_errors++;
      $display("Error: wait condition %0d expected 1 seen 0", k);
      test_done();
    end
  endtask

  initial begin
    int g;
    num_errors = 0;
    checks = 0;
    gaps = 0;
    ends = 0;
    cyc = 0;
    t0 = 0;
    srst = 1'b1;
    din = '0;
    cfg = '0;
    cfg.sequence_start_input_select = 3'h2;
    cfg.sequence_pause_input_select = 3'h5;
    cfg.stop_method_select = 1'b1;
    for (int i = 0; i < STEP_N; i++) cfg.fixed_frequency_setpoints[i] = 16'h0100 + 16'(i);
    cfg.step_run_times[0] = 10'h001;
    cfg.step_run_times[2] = 10'h002;
    cfg.step_run_times[6] = 10'h001;
    cfg.step_run_times[7] = 10'h001;
    cfg.relay1_function_select = FN_RUNNING;
    cfg.relay2_function_select = FN_STEP_END;
    cfg.transistor_output_function_select = FN_CYC_END;
    rows[0] = '{MODE_ONCE, 8'h00, 1'b0, 1'b0};
    rows[1] = '{MODE_CONT, 8'hc0, 1'b1, 1'b0};
    rows[2] = '{MODE_STEP_ONCE, 8'hc0, 1'b0, 1'b1};
    rows[3] = '{MODE_STEP_CONT, 8'h00, 1'b1, 1'b1};
    tick(6);
    srst = 1'b0;
    for (int r = 0; r < 4; r++) begin
      cfg.sequence_mode_select = rows[r].mode;
      cfg.direction_program_number = rows[r].dir;
      seen_step.delete();
      seen_rev.delete();
      seen_freq.delete();
      gaps = 0;
      ends = 0;
      set_pins(1'b1, 1'b0);
      wait_for(0, 600);
      g = gaps;
      tick(2);
      check("running", ro1, rows[r].run_after);
      check("step ends", ends, 4);
      check("gap seen", g != 0, rows[r].stepped);
      // Stepped rows add three gaps of seven cycles: model ramp plus the zero-speed sample
      check("cycle time", (cyc - t0 - (rows[r].stepped ? 21 : 0)) inside {[95:106]}, 1);
      for (int k = 0; k < 4; k++) begin
        check("step order", seen_step[k], exp_steps[k]);
        check("direction", seen_rev[k], rows[r].dir[exp_steps[k]]);
        check("setpoint", seen_freq[k], 16'h0100 + exp_steps[k]);
      end
      set_pins(1'b0, 1'b0);
      tick(8);
      check("idle run", drv.run, 0);
      $display("Row %0d done", r);
    end
    // Pause mid-cycle, then start removed and restarted
    cfg.sequence_mode_select = MODE_ONCE;
    cfg.transistor_output_function_select = FN_PAUSED;
    set_pins(1'b1, 1'b0);
    wait_for(3, 200);
    set_pins(1'b1, 1'b1);
    tick(8);
    check("paused run", drv.run, 0);
    check("paused out", dout, 1);
    tick(60);
    check("paused step", drv.step, 3'h2);
    set_pins(1'b1, 1'b0);
    tick(8);
    check("resumed run", drv.run, 1);
    check("resumed step", drv.step, 3'h2);
    check("pause cleared", dout, 0);
    wait_for(4, 200);
    set_pins(1'b0, 1'b0);
    tick(8);
    check("stop run", drv.run, 0);
    check("stop override", drv.override, 0);
    check("stop method", drv.coast, 1);
    check("stop running", ro1, 0);
    set_pins(1'b1, 1'b0);
    wait_for(1, 20);
    check("restart step", drv.step, 3'h0);
    set_pins(1'b0, 1'b0);
    tick(8);
    $display("Pause and restart done");
    // Invalid mode refuses to start; stop method follows its setting
    cfg.sequence_mode_select = 3'h0;
    cfg.stop_method_select = 1'b0;
    set_pins(1'b1, 1'b0);
    tick(30);
    check("refused run", drv.run, 0);
    check("refused override", drv.override, 0);
    check("ramp method", drv.coast, 0);
    $display("Refusal done");
    // Start held through reset starts without an edge
    cfg.sequence_mode_select = MODE_ONCE;
    srst = 1'b1;
    tick(6);
    check("reset run", drv.run, 0);
    check("reset running", ro1, 0);
    srst = 1'b0;
    wait_for(1, 20);
    check("auto step", drv.step, 3'h0);
    check("auto running", ro1, 1);
    $display("Auto start done");
    test_done();
  end
endmodule
